// ==== design/radio_baseband_packet_engine.sv ====
// Contract
// - continuous TX: drive bit clock, sample data rising
// - continuous RX, no bitsync: raw data, no clock
// - RX bitsync: data changes on falling clock edge
// - packet mode forces bitsync, data through FIFO
// - FIFO usable in sleep and standby
// - fixed format: format 0, nonzero count
// - fixed payload length one to 2047 bytes
// - variable format: first byte holds length
// - unlimited format: count not used for length
// - unlimited RX: no check, no ready events
// - TX adds preamble, sync, optional check bytes
// - before start: preamble or constant fill
// - launch select 1: start at first byte
// - launch select 0: wait threshold plus one
// - start condition met early: send at once
// - RX strips preamble, sync; payload to FIFO
// - fixed RX length from byte count
// - variable RX: drop if length above count
// - address mismatch stops reception
// - check result flag, ready on pin zero
`timescale 1ns/1ns
module radio_baseband_packet_engine #(
   parameter int FIFO_DEPTH = radio_pkt_pkg::FIFO_DEPTH_DEF,
   parameter int BIT_DIV = radio_pkt_pkg::BIT_DIV_DEF
)(
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic rf_clk_i,
   input wire radio_pkt_pkg::cfg_t cfg_i,
   input wire logic wr_valid_i,
   input wire logic [7:0] wr_data_i,
   input wire logic rd_req_i,
   output logic [7:0] rd_data_o,
   output logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_level_o,
   output logic fifo_empty_o,
   output logic check_pass_flag_o,
   output logic frame_available_flag_o,
   output logic gp_pin_zero_o,
   output logic packet_sent_o,
   input wire logic demod_bit_i,
   output logic mod_bit_o,
   input wire logic data_i,
   output logic data_o,
   output logic data_oe_o,
   output logic bit_clock_out_o
);
   localparam int AW = $clog2(FIFO_DEPTH);
   localparam int CW = $clog2(FIFO_DEPTH+1);
   localparam logic [7:0] DIV_LAST = 8'(BIT_DIV - 1);
   localparam logic [7:0] DIV_HALF = 8'(BIT_DIV / 2);

   typedef enum logic [2:0] {TX_PRE, TX_SYNC, TX_PAY, TX_CRC, TX_DONE} tx_state_t;
   typedef enum logic [1:0] {RX_HUNT, RX_PAY, RX_CRC, RX_HOLD} rx_state_t;

   // ---------------- Format decode ----------------
   logic fmt_var, fmt_unlim, tx_on, rx_on;
   assign fmt_var = cfg_i.frame_format_select;
   assign fmt_unlim = !cfg_i.frame_format_select && cfg_i.frame_byte_count == '0;
   assign tx_on = cfg_i.op_mode == radio_pkt_pkg::OP_TX && cfg_i.packet_mode;
   assign rx_on = cfg_i.op_mode == radio_pkt_pkg::OP_RX && cfg_i.packet_mode;

   // ---------------- Link clock domain ----------------
   radio_pkt_pkg::link_mode_t link_mode, mode_meta, mode_sync;
   logic [7:0] div;
   logic rise_tick, fall_tick, clk_en;
   logic data_meta, data_sync, tx_lvl_meta, tx_lvl_sync;
   logic tx_req_tgl, rx_tgl, rx_bit, tx_level;

   // Mode bits leave a core flop; packet mode always runs the bit synchronizer
   always_ff @(posedge core_clk_i or negedge resetn_i)
      if (!resetn_i)
         link_mode <= '0;
      else
      begin
         link_mode.tx <= cfg_i.op_mode == radio_pkt_pkg::OP_TX;
         link_mode.rx <= cfg_i.op_mode == radio_pkt_pkg::OP_RX;
         link_mode.packet <= cfg_i.packet_mode;
         link_mode.bitsync <= cfg_i.bitsync_enable || cfg_i.packet_mode;
      end

   // Two-stage synchronisers into the link domain
   always_ff @(posedge rf_clk_i or negedge resetn_i)
      if (!resetn_i)
      begin
         mode_meta <= '0;
         mode_sync <= '0;
         data_meta <= 1'b0;
         data_sync <= 1'b0;
         tx_lvl_meta <= 1'b0;
         tx_lvl_sync <= 1'b0;
      end
      else
      begin
         mode_meta <= link_mode;
         mode_sync <= mode_meta;
         data_meta <= data_i;
         data_sync <= data_meta;
         tx_lvl_meta <= tx_level;
         tx_lvl_sync <= tx_lvl_meta;
      end

   // Bit period divider; rising tick samples, falling tick updates
   always_ff @(posedge rf_clk_i or negedge resetn_i)
      if (!resetn_i)
         div <= '0;
      else
         div <= (div == DIV_LAST) ? '0 : div + 8'h01;

   assign rise_tick = div == '0;
   assign fall_tick = div == DIV_HALF;
   assign clk_en = !mode_sync.packet && (mode_sync.tx || (mode_sync.rx && mode_sync.bitsync));

   // Bit clock pin, only while continuous mode offers one
   always_ff @(posedge rf_clk_i or negedge resetn_i)
      if (!resetn_i)
         bit_clock_out_o <= 1'b0;
      else if (!clk_en)
         bit_clock_out_o <= 1'b0;
      else if (rise_tick)
         bit_clock_out_o <= 1'b1;
      else if (fall_tick)
         bit_clock_out_o <= 1'b0;

   // Modulator bit: the pin in continuous mode, the packet engine otherwise
   always_ff @(posedge rf_clk_i or negedge resetn_i)
      if (!resetn_i)
      begin
         mod_bit_o <= 1'b0;
         tx_req_tgl <= 1'b0;
      end
      else if (!mode_sync.tx)
         mod_bit_o <= 1'b0;
      else if (rise_tick)
      begin
         mod_bit_o <= mode_sync.packet ? tx_lvl_sync : data_sync;
         if (mode_sync.packet)
            tx_req_tgl <= !tx_req_tgl; // Ask the core for the next bit
      end

   // Demodulator side: bit handed to the core with a toggle, data held with it
   always_ff @(posedge rf_clk_i or negedge resetn_i)
      if (!resetn_i)
      begin
         rx_bit <= 1'b0;
         rx_tgl <= 1'b0;
      end
      else if (mode_sync.rx && mode_sync.packet && rise_tick)
      begin
         rx_bit <= demod_bit_i;
         rx_tgl <= !rx_tgl;
      end

   // Data pin: driven only in continuous receive
   always_ff @(posedge rf_clk_i or negedge resetn_i)
      if (!resetn_i)
      begin
         data_o <= 1'b0;
         data_oe_o <= 1'b0;
      end
      else if (mode_sync.rx && !mode_sync.packet)
      begin
         data_oe_o <= 1'b1;
         if (!mode_sync.bitsync)
            data_o <= demod_bit_i;
         else if (fall_tick)
            data_o <= demod_bit_i;
      end
      else
      begin
         data_o <= 1'b0;
         data_oe_o <= 1'b0;
      end

   // ---------------- Toggle crossings into the core ----------------
   logic [2:0] tx_req_sh, rx_evt_sh;
   logic tx_req_evt, rx_evt;

   // Third stage only remembers the old value for edge detection
   always_ff @(posedge core_clk_i or negedge resetn_i)
      if (!resetn_i)
      begin
         tx_req_sh <= '0;
         rx_evt_sh <= '0;
      end
      else
      begin
         tx_req_sh <= {tx_req_sh[1:0], tx_req_tgl};
         rx_evt_sh <= {rx_evt_sh[1:0], rx_tgl};
      end

   assign tx_req_evt = tx_req_sh[2] ^ tx_req_sh[1];
   assign rx_evt = rx_evt_sh[2] ^ rx_evt_sh[1];

   // ---------------- FIFO ----------------
   logic [7:0] mem [FIFO_DEPTH];
   logic [AW-1:0] wp, rp;
   logic [CW-1:0] count, next_count;
   logic has_room, user_push, any_push, user_pop, any_pop, tx_pop, rx_push, fifo_clear;
   logic [7:0] push_data, rx_new;

   // Handler pushes win; software access stays open in sleep and standby
   assign has_room = int'(count) < FIFO_DEPTH;
   assign user_push = wr_valid_i && !rx_push && has_room;
   assign any_push = (rx_push && has_room) || user_push;
   assign push_data = rx_push ? rx_new : wr_data_i;
   assign user_pop = rd_req_i && !tx_on && count != '0;
   assign any_pop = (tx_pop || user_pop) && count != '0;
   assign next_count = count + CW'(any_push) - CW'(any_pop);

   always_ff @(posedge core_clk_i)
      if (any_push)
         mem[wp] <= push_data;

   always_ff @(posedge core_clk_i or negedge resetn_i)
      if (!resetn_i)
      begin
         wp <= '0;
         rp <= '0;
         count <= '0;
         fifo_empty_o <= 1'b1;
         rd_data_o <= '0;
      end
      else if (fifo_clear)
      begin
         rp <= wp;
         count <= '0;
         fifo_empty_o <= 1'b1;
      end
      else
      begin
         if (any_push)
            wp <= wp + 1'b1;
         if (any_pop)
            rp <= rp + 1'b1;
         if (user_pop)
            rd_data_o <= mem[rp];
         count <= next_count;
         fifo_empty_o <= next_count == '0;
      end

   assign fifo_level_o = count;

   // ---------------- Transmit packet builder ----------------
   tx_state_t tx_state, next_tx_state;
   logic [7:0] tx_sh, next_tx_byte, pre_sent;
   logic [2:0] tx_bits;
   logic [10:0] tx_left, tx_rem;
   logic [15:0] tx_crc;
   logic tx_idx, tx_first, tx_feed, next_tx_feed, start_ok, tx_load;

   // Launch select 1 needs one byte, 0 needs threshold plus one bytes
   assign start_ok = cfg_i.transmit_launch_select ? count != '0 :
                     int'(count) > int'(cfg_i.queue_threshold_level);
   assign tx_load = tx_on && tx_req_evt && tx_bits == '0;

   // Pick the byte for the next load and the state after it
   always_comb
   begin
      next_tx_byte = radio_pkt_pkg::FILL_BYTE;
      next_tx_state = tx_state;
      next_tx_feed = 1'b0;
      tx_pop = 1'b0;
      tx_rem = tx_left - 11'h001;
      if (tx_first)
         tx_rem = fmt_var ? {3'h0, mem[rp]} : cfg_i.frame_byte_count - 11'h001;
      case (tx_state)
         TX_PRE:
         begin
            if (cfg_i.preamble_bytes != '0)
               next_tx_byte = radio_pkt_pkg::PREAMBLE_BYTE;
            if (start_ok && {1'b0, pre_sent} + 9'h001 >= {1'b0, cfg_i.preamble_bytes})
               next_tx_state = cfg_i.sync_pattern_enable ? TX_SYNC : TX_PAY;
         end
         TX_SYNC:
         begin
            next_tx_byte = tx_idx ? cfg_i.sync_word[7:0] : cfg_i.sync_word[15:8];
            if (tx_idx)
               next_tx_state = TX_PAY;
         end
         TX_PAY:
         begin
            if (count != '0)
               next_tx_byte = mem[rp];
            tx_pop = tx_load;
            next_tx_feed = 1'b1;
            if (fmt_unlim ? int'(count) <= 1 : tx_rem == '0)
               next_tx_state = cfg_i.check_enable ? TX_CRC : TX_DONE;
         end
         TX_CRC:
         begin
            next_tx_byte = tx_idx ? ~tx_crc[7:0] : ~tx_crc[15:8];
            if (tx_idx)
               next_tx_state = TX_DONE;
         end
         TX_DONE: next_tx_state = TX_DONE;
         default: next_tx_state = TX_PRE;
      endcase
   end

   // Serialiser and sequencing; one bit leaves per request from the link
   always_ff @(posedge core_clk_i or negedge resetn_i)
      if (!resetn_i)
      begin
         tx_state <= TX_PRE;
         tx_sh <= '0;
         tx_bits <= '0;
         tx_level <= 1'b0;
         pre_sent <= '0;
         tx_left <= '0;
         tx_crc <= radio_pkt_pkg::CRC_SEED;
         tx_idx <= 1'b0;
         tx_first <= 1'b1;
         tx_feed <= 1'b0;
         packet_sent_o <= 1'b0;
      end
      else if (!tx_on)
      begin
         tx_state <= TX_PRE;
         tx_bits <= '0;
         tx_level <= 1'b0;
         pre_sent <= '0;
         tx_crc <= radio_pkt_pkg::CRC_SEED;
         tx_idx <= 1'b0;
         tx_first <= 1'b1;
         tx_feed <= 1'b0;
         packet_sent_o <= 1'b0;
      end
      else
      begin
         packet_sent_o <= 1'b0;
         if (tx_load)
         begin
            tx_level <= next_tx_byte[7];
            tx_sh <= {next_tx_byte[6:0], 1'b0};
            tx_bits <= radio_pkt_pkg::BYTE_LAST_BIT;
            tx_feed <= next_tx_feed;
            if (next_tx_feed)
               tx_crc <= radio_pkt_pkg::crc_step(tx_crc, next_tx_byte[7]);
            if (tx_state == TX_PRE && pre_sent != 8'hFF)
               pre_sent <= pre_sent + 8'h01;
            if (tx_state == TX_PAY)
            begin
               tx_left <= tx_rem;
               tx_first <= 1'b0;
            end
            tx_idx <= (next_tx_state == tx_state) ? !tx_idx : 1'b0;
            tx_state <= next_tx_state;
            packet_sent_o <= next_tx_state == TX_DONE && tx_state != TX_DONE;
         end
         else if (tx_req_evt)
         begin
            tx_level <= tx_sh[7];
            tx_sh <= {tx_sh[6:0], 1'b0};
            tx_bits <= tx_bits - 3'h1;
            if (tx_feed)
               tx_crc <= radio_pkt_pkg::crc_step(tx_crc, tx_sh[7]);
         end
      end

   // ---------------- Receive packet stripper ----------------
   rx_state_t rx_state;
   logic [15:0] rx_win, rx_crc, rx_cbuf;
   logic [6:0] rx_sh;
   logic [2:0] rx_bits;
   logic [3:0] rx_cbits;
   logic [1:0] rx_idx;
   logic [10:0] rx_left, rx_rem;
   logic rx_byte_done, rx_len_bad, rx_addr_bad, rx_last, crc_done, rx_pass;
   logic rx_sync_hit, rx_start, rx_finish, rx_ok, frame_available;

   assign rx_new = {rx_sh, rx_bit};
   assign rx_sync_hit = cfg_i.sync_pattern_enable ? {rx_win[14:0], rx_bit} == cfg_i.sync_word :
                        cfg_i.queue_fill_rule;
   assign rx_start = rx_on && rx_evt && rx_state == RX_HUNT && rx_sync_hit;
   assign rx_byte_done = rx_on && rx_evt && rx_state == RX_PAY && rx_bits == radio_pkt_pkg::BYTE_LAST_BIT;
   assign rx_len_bad = fmt_var && rx_idx == '0 && {3'h0, rx_new} > cfg_i.frame_byte_count;
   assign rx_addr_bad = cfg_i.address_check_enable && !(fmt_unlim && !cfg_i.sync_pattern_enable)
                        && rx_idx == (fmt_var ? radio_pkt_pkg::ADDR_IDX_VAR : radio_pkt_pkg::ADDR_IDX_FIXED)
                        && rx_new != cfg_i.station_id;
   assign rx_push = rx_byte_done && !rx_len_bad && !rx_addr_bad;
   assign rx_rem = (rx_idx != '0) ? rx_left - 11'h001 :
                   fmt_var ? {3'h0, rx_new} : cfg_i.frame_byte_count - 11'h001;
   assign rx_last = rx_push && !fmt_unlim && rx_rem == '0;
   assign crc_done = rx_on && rx_evt && rx_state == RX_CRC && rx_cbits == radio_pkt_pkg::CRC_LAST_BIT;
   assign rx_pass = {rx_cbuf[14:0], rx_bit} == ~rx_crc;
   assign rx_finish = (rx_last && !cfg_i.check_enable) || crc_done;
   assign rx_ok = !crc_done || rx_pass || cfg_i.keep_on_check_fail;
   assign fifo_clear = crc_done && !rx_pass && !cfg_i.keep_on_check_fail;

   // Hunt for sync, then assemble bytes and count them down
   always_ff @(posedge core_clk_i or negedge resetn_i)
      if (!resetn_i)
      begin
         rx_state <= RX_HUNT;
         rx_win <= '0;
         rx_sh <= '0;
         rx_bits <= '0;
         rx_cbits <= '0;
         rx_idx <= '0;
         rx_left <= '0;
         rx_crc <= radio_pkt_pkg::CRC_SEED;
         rx_cbuf <= '0;
      end
      else if (!rx_on)
      begin
         rx_state <= RX_HUNT;
         rx_win <= '0;
      end
      else if (rx_evt)
         case (rx_state)
            RX_HUNT:
            begin
               rx_win <= {rx_win[14:0], rx_bit};
               rx_bits <= '0;
               rx_cbits <= '0;
               rx_idx <= '0;
               rx_crc <= radio_pkt_pkg::CRC_SEED;
               if (rx_sync_hit)
                  rx_state <= RX_PAY;
            end
            RX_PAY:
            begin
               rx_sh <= rx_new[6:0];
               rx_bits <= rx_bits + 3'h1;
               rx_crc <= radio_pkt_pkg::crc_step(rx_crc, rx_bit);
               if (rx_byte_done)
               begin
                  rx_left <= rx_rem;
                  if (rx_idx != 2'h3)
                     rx_idx <= rx_idx + 2'h1;
                  if (!rx_push)
                     rx_state <= RX_HUNT;
                  else if (rx_last)
                     rx_state <= cfg_i.check_enable ? RX_CRC : RX_HOLD;
               end
            end
            RX_CRC:
            begin
               rx_cbuf <= {rx_cbuf[14:0], rx_bit};
               rx_cbits <= rx_cbits + 4'h1;
               if (crc_done)
                  rx_state <= RX_HOLD;
            end
            RX_HOLD: rx_state <= RX_HOLD;
            default: rx_state <= RX_HUNT;
         endcase

   // Result flags; a set in the same cycle as a clear wins
   always_ff @(posedge core_clk_i or negedge resetn_i)
      if (!resetn_i)
      begin
         frame_available <= 1'b0;
         check_pass_flag_o <= 1'b0;
      end
      else
      begin
         if (rx_finish && rx_ok && !fmt_unlim)
            frame_available <= 1'b1;
         else if (count == '0 || rx_start)
            frame_available <= 1'b0;
         if (crc_done)
            check_pass_flag_o <= rx_pass;
         else if (rx_start)
            check_pass_flag_o <= 1'b0;
      end

   assign frame_available_flag_o = frame_available;
   assign gp_pin_zero_o = frame_available;

   // ---------------- Checks ----------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_rx_fail;
      crc_done && !rx_pass;
   endsequence

   a_fail_clears: assert property (s_rx_fail ##0 !cfg_i.keep_on_check_fail |=>
      count == '0 && !frame_available) else $error("failed check did not clear");
   a_fail_kept: assert property (s_rx_fail ##0 cfg_i.keep_on_check_fail |=>
      frame_available && !check_pass_flag_o) else $error("kept frame not flagged");
   a_pass_ready: assert property (crc_done && rx_pass |=>
      frame_available && check_pass_flag_o) else $error("passing frame not flagged");
   a_unlim_no_ready: assert property (fmt_unlim && !frame_available |=>
      !frame_available) else $error("ready raised in unlimited format");
   a_len_discard: assert property (rx_byte_done && rx_len_bad |=>
      rx_state == RX_HUNT) else $error("oversize length not discarded");
   a_addr_stop: assert property (rx_byte_done && rx_addr_bad && !rx_len_bad |=>
      rx_state == RX_HUNT) else $error("address mismatch not stopped");
   a_standby_write: assert property (cfg_i.op_mode == radio_pkt_pkg::OP_STANDBY && wr_valid_i
      && has_room && !rd_req_i |=> count == $past(count) + 1'b1)
      else $error("standby write lost");
   a_tx_holds: assert property (tx_load && tx_state == TX_PRE && !start_ok |=>
      tx_state == TX_PRE) else $error("packet left preamble before start");
   a_tx_launch: assert property (tx_load && tx_state == TX_PRE && start_ok
      && pre_sent >= cfg_i.preamble_bytes |=> tx_state != TX_PRE) else $error("launch delayed");
   a_raw_no_clock: assert property (@(posedge rf_clk_i) disable iff (!resetn_i)
      mode_sync.rx && !mode_sync.packet && !mode_sync.bitsync |=>
      !bit_clock_out_o && data_oe_o) else $error("raw receive shows a clock");
   a_pkt_pin_idle: assert property (@(posedge rf_clk_i) disable iff (!resetn_i)
      mode_sync.packet |=> !data_oe_o) else $error("packet mode drives data pin");
   a_rx_fall_only: assert property (@(posedge rf_clk_i) disable iff (!resetn_i)
      mode_sync.rx && !mode_sync.packet && mode_sync.bitsync && !fall_tick && data_oe_o |=>
      data_o == $past(data_o)) else $error("data moved off the falling edge");
   a_tx_sample: assert property (@(posedge rf_clk_i) disable iff (!resetn_i)
      mode_sync.tx && !mode_sync.packet && rise_tick |=>
      mod_bit_o == $past(data_sync)) else $error("data not sampled at rising edge");
endmodule

// ==== design/radio_pkt_pkg.sv ====
package radio_pkt_pkg;
   // Structure and timing defaults
   localparam int FIFO_DEPTH_DEF = 64;
   localparam int BIT_DIV_DEF = 16;
   // Fixed byte values put on air
   localparam logic [7:0] PREAMBLE_BYTE = 8'hAA;
   localparam logic [7:0] FILL_BYTE = 8'h00;
   // Check sequence: x16 + x12 + x5 + 1, seeded, sent complemented
   localparam logic [15:0] CRC_SEED = 16'h1D0F;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
   localparam logic [3:0] CRC_LAST_BIT = 4'hF;
   localparam logic [1:0] ADDR_IDX_FIXED = 2'h0;
   localparam logic [1:0] ADDR_IDX_VAR = 2'h1;

   typedef enum logic [1:0] {OP_SLEEP, OP_STANDBY, OP_TX, OP_RX} op_mode_t;

   // Static configuration, written by software while the link is idle
   typedef struct packed {
      op_mode_t op_mode;
      logic packet_mode;
      logic bitsync_enable;
      logic frame_format_select;
      logic [10:0] frame_byte_count;
      logic transmit_launch_select;
      logic [5:0] queue_threshold_level;
      logic [7:0] preamble_bytes;
      logic sync_pattern_enable;
      logic [15:0] sync_word;
      logic queue_fill_rule;
      logic address_check_enable;
      logic [7:0] station_id;
      logic check_enable;
      logic keep_on_check_fail;
   } cfg_t;

   // Mode levels handed to the link clock domain
   typedef struct packed {
      logic tx;
      logic rx;
      logic packet;
      logic bitsync;
   } link_mode_t;

   // One bit of the check sequence, msb first
   function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic din);
      crc_step = {crc[14:0], 1'b0} ^ ((crc[15] ^ din) ? CRC_POLY : 16'h0000);
   endfunction
endpackage

// ==== tb/link_partner.sv ====
`timescale 1ns/1ns
module link_partner #(
   parameter int BIT_DIV = 16
)(
   input wire logic rf_clk_i,
   input wire logic resetn_i,
   input wire logic bit_clock_out_i,
   input wire logic send_i,
   input wire logic [63:0] frame_i,
   output logic data_o,
   output logic demod_o,
   output logic mid_o
);
   logic [7:0] phase;
   logic [63:0] sr;
   logic [6:0] left;
   logic send_d;
   logic [7:0] pat;
   // Bit phase tracks the device divider; both restart at reset
   always_ff @(posedge rf_clk_i or negedge resetn_i)
      if (!resetn_i)
         phase <= 8'h00;
      else
         phase <= (phase == 8'(BIT_DIV - 1)) ? 8'h00 : phase + 8'h01;
   assign mid_o = (phase == 8'(BIT_DIV / 2));
   // Bits change mid-bit; between frames the line toggles so no stale level shows
   always_ff @(posedge rf_clk_i or negedge resetn_i)
      if (!resetn_i)
      begin
         send_d <= 1'b0;
         left <= 7'h00;
         demod_o <= 1'b0;
         sr <= '0;
      end
      else
      begin
         send_d <= send_i;
         if (send_i && !send_d)
         begin
            sr <= frame_i;
            left <= 7'h41;
         end
         else if (mid_o && left != 7'h00)
         begin
            demod_o <= (left > 7'h01) ? sr[63] : ~demod_o;
            sr <= {sr[62:0], 1'b0};
            left <= left - 7'h01;
         end
         else if (left == 7'h00)
            demod_o <= ~demod_o;
      end
   // Data moves on the falling bit clock, clear of the rising sample
   always_ff @(negedge bit_clock_out_i or negedge resetn_i)
      if (!resetn_i)
         pat <= 8'hCA;
      else
         pat <= {pat[6:0], pat[7]};
   assign data_o = pat[7];
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ns
module tb;
   localparam logic [15:0] SYNC = 16'h5A3C;
   logic clk = 0, rclk = 0, rst_n = 0, wv = 0, rq = 0, send = 0, ctx_on = 0, held = 0, found = 0;
   logic [7:0] wd = 8'h00, rdd;
   logic [63:0] frame = '0;
   logic [55:0] sh = '0, exp_tx;
   logic [6:0] lvl;
   logic [5:0] r;
   logic [15:0] d;
   logic emp, pass, avail, gp0, sent, mbit, dout, doe, bclk, pdat, demod, mid;
   int n_fail = 0, n_checks = 0, n_sent = 0, edges = 0, k;
   logic [5:0] rows [5] = '{6'h03, 6'h08, 6'h1A, 6'h20, 6'h04}; // fmt keep bad adr avail pass
   radio_pkt_pkg::cfg_t cfg = '0;
   wire logic pin = doe ? dout : pdat;
   radio_baseband_packet_engine #(.FIFO_DEPTH(64), .BIT_DIV(16)) dut (.core_clk_i(clk),
      .resetn_i(rst_n), .rf_clk_i(rclk), .cfg_i(cfg), .wr_valid_i(wv), .wr_data_i(wd),
      .rd_req_i(rq), .rd_data_o(rdd), .fifo_level_o(lvl), .fifo_empty_o(emp),
      .check_pass_flag_o(pass), .frame_available_flag_o(avail), .gp_pin_zero_o(gp0),
      .packet_sent_o(sent), .demod_bit_i(demod), .mod_bit_o(mbit), .data_i(pin),
      .data_o(dout), .data_oe_o(doe), .bit_clock_out_o(bclk));
   link_partner #(.BIT_DIV(16)) peer (.rf_clk_i(rclk), .resetn_i(rst_n), .bit_clock_out_i(bclk),
      .send_i(send), .frame_i(frame), .data_o(pdat), .demod_o(demod), .mid_o(mid));
   // Two unrelated clocks
   initial forever #10 clk = ~clk;
   initial
   begin
      #3;
      forever #6 rclk = ~rclk;
   end
   function automatic logic [15:0] crc16(input logic [15:0] v);
      logic [15:0] c;
      c = 16'h1D0F;
      for (int i = 15; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ v[i]) ? 16'h1021 : 16'h0000);
      return ~c;
   endfunction
   task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task wr(input logic [7:0] b);
      @(posedge clk) {wv, wd} <= {1'b1, b};
      @(posedge clk) wv <= 1'b0;
   endtask
   task rd(input logic [7:0] e);
      @(posedge clk) rq <= 1'b1;
      @(posedge clk) rq <= 1'b0;
      @(negedge clk) chk("rd_data", rdd, e);
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Monitors: sent pulses, bit clock, serial capture at mid-bit
   always @(negedge clk) if (sent === 1'b1) n_sent++;
   always @(posedge bclk)
   begin
      edges++;
      held <= pdat;
   end
   always @(negedge bclk) if (ctx_on) chk("tx_bit", mbit, held);
   always @(posedge rclk)
   begin
      if (mid) sh <= {sh[54:0], mbit};
      if (sh === exp_tx) found <= 1'b1;
   end
   // Whole run is near 9000 cycles
   initial
   begin
      repeat (60000) @(posedge clk);
      n_fail++;
      summarize;
   end
   initial
   begin
      exp_tx = {8'hAA, SYNC, 16'h3CC3, crc16(16'h3CC3)};
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      wr(8'h11);
      wr(8'h22);
      wr(8'h33);
      @(negedge clk) chk("level", lvl, 3);
      rd(8'h11);
      rd(8'h22);
      rd(8'h33);
      chk("empty", emp, 1);
      @(posedge clk) cfg.op_mode <= radio_pkt_pkg::OP_TX;
      repeat (40) @(posedge clk) ctx_on <= 1'b1;
      repeat (400) @(posedge clk) ctx_on <= 1'b0;
      chk("bclk_edges", edges != 0, 1);
      for (int b = 0; b < 2; b++)
      begin
         @(posedge clk) cfg.op_mode <= radio_pkt_pkg::OP_RX;
         cfg.bitsync_enable <= b[0];
         repeat (20) @(posedge clk);
         k = edges;
         repeat (200) @(posedge clk);
         chk("rx_clock", edges != k, b[0]);
         chk("data_oe", doe, 1);
         if (!b[0]) @(negedge rclk) chk("raw_data", dout, !demod);
      end
      @(posedge clk) cfg <= '0;
      @(posedge clk) {cfg.packet_mode, cfg.frame_byte_count, cfg.queue_threshold_level} <= 18'h20081;
      {cfg.preamble_bytes, cfg.sync_pattern_enable, cfg.sync_word, cfg.check_enable} <= {8'h01, 1'b1, SYNC, 1'b1};
      {cfg.station_id, cfg.op_mode} <= {8'h77, radio_pkt_pkg::OP_STANDBY};
      wr(8'h3C);
      @(posedge clk) cfg.op_mode <= radio_pkt_pkg::OP_TX;
      repeat (1500) @(negedge clk);
      chk("early_sent", n_sent, 0);
      wr(8'hC3);
      for (k = 0; k < 3000 && n_sent == 0; k++) @(negedge clk);
      repeat (400) @(negedge clk);
      chk("sent", n_sent, 1);
      chk("frame", found, 1);
      // One byte only: launch select 1 must start, threshold rule never would
      @(posedge clk) {cfg.op_mode, cfg.transmit_launch_select} <= {radio_pkt_pkg::OP_STANDBY, 1'b1};
      wr(8'h3C);
      @(posedge clk) cfg.op_mode <= radio_pkt_pkg::OP_TX;
      repeat (700) @(negedge clk);
      chk("sent_at_once", n_sent, 2);
      for (int i = 0; i < 5; i++)
      begin
         r = rows[i];
         d = {r[5] ? 8'h05 : 8'h3C, 8'hC3};
         @(posedge clk) {cfg.op_mode, cfg.frame_format_select} <= {radio_pkt_pkg::OP_RX, r[5]};
         {cfg.keep_on_check_fail, cfg.address_check_enable} <= {r[4], r[2]};
         frame <= {16'hAAAA, SYNC, d, crc16(d) ^ {15'h0000, r[3]}};
         repeat (20) @(posedge clk) send <= 1'b1;
         for (k = 0; k < 1000 && avail !== 1'b1; k++) @(negedge clk);
         repeat (100) @(negedge clk);
         chk("avail", avail, r[1]);
         chk("pin_zero", gp0, r[1]);
         chk("pass", pass, r[0]);
         @(posedge clk) {send, cfg.op_mode} <= {1'b0, radio_pkt_pkg::OP_STANDBY};
         repeat (10) @(negedge clk);
         chk("rx_level", lvl, r[1] ? 2 : 0);
         if (r[1]) rd(d[15:8]);
         if (r[1]) rd(d[7:0]);
      end
      summarize;
   end
endmodule
